// ==== irq_nest_pkg.sv ====
// Purpose: shared constants for the nested interrupt priority controller
// Assumes: 8-bit registers placed on a 32-bit apb, one aligned word each
// Notes:   offsets are register indices; byte address is four times the index
`default_nettype none
package irq_nest_pkg;
	// ==================================================================
	// register indices
	localparam logic [7:0] IDX_PRIO0  = 8'h24;
	localparam logic [7:0] IDX_PRIO1  = 8'h25;
	localparam logic [7:0] IDX_PRIO2  = 8'h26;
	localparam logic [7:0] IDX_PRIO3  = 8'h27;
	localparam logic [7:0] IDX_SENSE  = 8'h28;
	localparam logic [7:0] IDX_CCF    = 8'h29;
	localparam logic [7:0] IDX_STATUS = 8'h2a;
	// ==================================================================
	// reset values, read-only bits and write mask
	localparam logic [7:0] CC_RST    = 8'hfa;
	localparam logic [7:0] PRIO_RST  = 8'hff;
	localparam logic [7:0] SENSE_RST = 8'h00;
	localparam logic [7:0] PRIO3_RO  = 8'hf0;
	localparam logic [7:0] SENSE_WM  = 8'hfc;
	// ==================================================================
	// condition register fields
	localparam int CC_HI = 5;
	localparam int CC_LO = 3;
	localparam logic [1:0] LVL0_PAT = 2'h2;
	localparam logic [1:0] LVL3_PAT = 2'h3;
	// ==================================================================
	// sense control fields
	localparam int SN_UPPER = 6;
	localparam int SN_POLB  = 5;
	localparam int SN_LOWER = 3;
	localparam int SN_POLA  = 2;
	localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
	localparam logic [1:0] SENSE_RISE     = 2'h1;
	localparam logic [1:0] SENSE_FALL     = 2'h2;
	localparam logic [1:0] SENSE_BOTH     = 2'h3;
	// ==================================================================
	// vectors
	localparam int NVEC     = 14;
	localparam int VEC_TB   = 1;
	localparam int VEC_EXT0 = 2;
	localparam int VEC_SPI  = 7;
	localparam logic [15:0] VADDR_RESET = 16'hfffe;
	localparam logic [15:0] VADDR_TRAP  = 16'hfffc;
	localparam logic [15:0] VADDR_V0    = 16'hfffa;
	localparam logic [13:0] VEC_USED    = 14'h3fbe;
endpackage
`default_nettype wire

// ==== nested_irq_priority_ctrl.sv ====
// Purpose: priority nesting, vector choice and external sense for a cpu core
// Assumes: cpu strobes are one-cycle pulses synchronous to pclk
// Notes:   zero-wait apb slave, read data registered in the setup cycle
`timescale 1ns/1ns
`default_nettype none
module nested_irq_priority_ctrl #(
	parameter bit MASK_ROM_VARIANT = 1'b0,
	parameter int NG0 = 4,
	parameter int NG1 = 3,
	parameter int NG2 = 4,
	parameter int NG3 = 4
) (
	input  wire logic             pclk,             // cpu clock
	input  wire logic             presetn,          // async reset, low
	input  wire logic             psel,             // apb select
	input  wire logic             penable,          // apb access phase
	input  wire logic             pwrite,           // apb direction
	input  wire logic [9:0]       paddr,            // apb byte address
	input  wire logic [31:0]      pwdata,           // apb write data
	output logic                  pready,           // apb ready
	output logic [31:0]           prdata,           // apb read data
	output logic                  pslverr,          // unmapped access
	input  wire logic             enable_irq_instr, // pulse
	input  wire logic             disable_irq_instr,// pulse
	input  wire logic             halt_instr,       // pulse
	input  wire logic             wait_for_irq_instr, // pulse
	input  wire logic             pop_cc_instr,     // pulse, stack_cc valid
	input  wire logic             return_from_irq_instr, // pulse
	input  wire logic [7:0]       stack_cc,         // popped condition byte
	input  wire logic             trap_take,        // trap entered
	input  wire logic             irq_take,         // vector entered
	input  wire logic [3:0]       irq_take_vec,     // vector entered
	input  wire logic [irq_nest_pkg::NVEC-1:0] periph_irq, // peripheral levels
	input  wire logic [NG0-1:0]   ext_line_group_0, // pins vector 2
	input  wire logic [NG1-1:0]   ext_line_group_1, // pins vector 3
	input  wire logic [NG2-1:0]   ext_line_group_2, // pins vector 4
	input  wire logic [NG3-1:0]   ext_line_group_3, // pins vector 5
	output logic [7:0]            cpu_condition_flags, // condition byte
	output logic                  irq_req,          // request to cpu
	output logic [3:0]            irq_vec,          // chosen vector
	output logic [15:0]           irq_vaddr,        // its table address
	output logic [15:0]           reset_vaddr,      // reset entry
	output logic [15:0]           trap_vaddr,       // trap entry
	output logic                  branch_if_masked, // level three
	output logic                  branch_if_unmasked, // not level three
	output logic                  halt_wake,        // wake from halt
	output logic                  active_halt_wake  // wake from active halt
);
	localparam int NVEC_M1 = irq_nest_pkg::NVEC - 1;

	// ==================================================================
	// helpers
	// bit pattern to numeric level
	function automatic logic [1:0] lvl(input logic [1:0] p);
		case (p)
			2'h2:    lvl = 2'h0;
			2'h1:    lvl = 2'h1;
			2'h0:    lvl = 2'h2;
			default: lvl = 2'h3;
		endcase
	endfunction

	// field update that refuses the level-0 pattern
	function automatic logic [7:0] fld_wr(input logic [7:0] o, input logic [7:0] n);
		logic [7:0] r;
		r = n;
		for (int i = 0; i < 4; i++)
			if (n[2*i+:2] == irq_nest_pkg::LVL0_PAT)
				r[2*i+:2] = o[2*i+:2];
		fld_wr = r;
	endfunction

	// ==================================================================
	// register state
	logic [7:0]  cc_r;
	logic [31:0] prio_r;
	logic [7:0]  sense_r;
	logic [3:0]  edge_r;
	logic [3:0]  prev_r;
	logic [7:0]  rd_r;
	logic        err_r;
	logic        req_r;
	logic [3:0]  vec_r;
	logic [15:0] vaddr_r;
	logic        hw_r;
	logic        ahw_r;

	logic [1:0]  cur_pat;
	logic        lvl3;
	logic        wr_en;
	logic        rd_setup;
	logic [7:0]  idx;
	logic        idx_ok;
	logic [7:0]  sense_nxt;

	assign cur_pat  = {cc_r[irq_nest_pkg::CC_HI], cc_r[irq_nest_pkg::CC_LO]};
	assign lvl3     = (cur_pat == irq_nest_pkg::LVL3_PAT);
	assign idx      = paddr[9:2];
	assign idx_ok   = (idx >= irq_nest_pkg::IDX_PRIO0) && (idx <= irq_nest_pkg::IDX_STATUS)
			&& (paddr[1:0] == 2'h0);
	assign wr_en    = psel && penable && pwrite && idx_ok;
	assign rd_setup = psel && !penable;

	// ==================================================================
	// external sense: pins ored per group, polarity folded in
	logic [3:0] line;
	logic [3:0] xl;
	logic [3:0] xp;
	logic [1:0] mode [4];
	logic [3:0] edge_hit;
	logic [3:0] lvl_hit;
	logic [3:0] ext_pend;

	assign line = {|ext_line_group_3, |ext_line_group_2,
			|ext_line_group_1, |ext_line_group_0};
	// polarity only touches the lower group of each pair
	assign xl = line ^ {1'b0, sense_r[irq_nest_pkg::SN_POLB],
			1'b0, sense_r[irq_nest_pkg::SN_POLA]};
	assign xp = prev_r ^ {1'b0, sense_r[irq_nest_pkg::SN_POLB],
			1'b0, sense_r[irq_nest_pkg::SN_POLA]};
	assign mode[0] = sense_r[irq_nest_pkg::SN_LOWER+:2];
	assign mode[1] = sense_r[irq_nest_pkg::SN_LOWER+:2];
	assign mode[2] = sense_r[irq_nest_pkg::SN_UPPER+:2];
	assign mode[3] = sense_r[irq_nest_pkg::SN_UPPER+:2];

	// edge and level qualification per group
	always_comb
	begin
		for (int g = 0; g < 4; g++)
		begin
			case (mode[g])
				irq_nest_pkg::SENSE_RISE: edge_hit[g] = xl[g] && !xp[g];
				irq_nest_pkg::SENSE_BOTH: edge_hit[g] = xl[g] != xp[g];
				default:                  edge_hit[g] = !xl[g] && xp[g];
			endcase
			lvl_hit[g] = (mode[g] == irq_nest_pkg::SENSE_FALL_LOW) && !xl[g];
		end
	end

	assign ext_pend = edge_r | lvl_hit;

	// previous pin level, used for edge detection
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prev_r <= 4'h0;
		else
			prev_r <= line;
	end

	// sense register: accepted only at level three
	always_comb
	begin
		sense_nxt = sense_r;
		if (wr_en && idx == irq_nest_pkg::IDX_SENSE && lvl3)
			sense_nxt = pwdata[7:0] & irq_nest_pkg::SENSE_WM;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sense_r <= irq_nest_pkg::SENSE_RST;
		else
			sense_r <= sense_nxt;
	end

	// edge latches: new edge wins over entry clear and sense clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			edge_r <= 4'h0;
		else
		begin
			for (int g = 0; g < 4; g++)
			begin
				if (edge_hit[g])
					edge_r[g] <= 1'b1;
				else if (sense_nxt != sense_r)
					edge_r[g] <= 1'b0;
				else if (irq_take && irq_take_vec == 4'(irq_nest_pkg::VEC_EXT0 + g))
					edge_r[g] <= 1'b0;
			end
		end
	end

	// ==================================================================
	// pending set and arbitration
	logic [NVEC_M1:0] pend;
	logic [1:0]       best_l;
	logic [3:0]       best_v;
	logic             best_ok;

	always_comb
	begin
		pend = periph_irq;
		pend[irq_nest_pkg::VEC_EXT0+:4] = ext_pend;
		pend = pend & irq_nest_pkg::VEC_USED;
	end

	// walk from lowest hardware priority up so ties go to lower numbers
	always_comb
	begin
		best_ok = 1'b0;
		best_l  = 2'h0;
		best_v  = 4'h0;
		for (int n = NVEC_M1; n >= 0; n--)
		begin
			if (pend[n] && lvl(prio_r[2*n+:2]) > lvl(cur_pat)
					&& (!best_ok || lvl(prio_r[2*n+:2]) >= best_l))
			begin
				best_ok = 1'b1;
				best_l  = lvl(prio_r[2*n+:2]);
				best_v  = 4'(n);
			end
		end
	end

	// registered request and vector address
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			req_r   <= 1'b0;
			vec_r   <= 4'h0;
			vaddr_r <= irq_nest_pkg::VADDR_V0;
		end
		else
		begin
			req_r   <= best_ok;
			vec_r   <= best_v;
			vaddr_r <= irq_nest_pkg::VADDR_V0 - {11'h0, best_v, 1'b0};
		end
	end

	// ==================================================================
	// condition register: entry beats trap beats restore beats instructions
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cc_r <= irq_nest_pkg::CC_RST;
		else if (irq_take)
		begin
			cc_r[irq_nest_pkg::CC_HI] <= prio_r[2*irq_take_vec+1];
			cc_r[irq_nest_pkg::CC_LO] <= prio_r[2*irq_take_vec];
		end
		else if (trap_take)
		begin
			cc_r[irq_nest_pkg::CC_HI] <= 1'b1;
			cc_r[irq_nest_pkg::CC_LO] <= 1'b1;
		end
		else if (return_from_irq_instr || pop_cc_instr)
			cc_r <= stack_cc;
		else if (enable_irq_instr || halt_instr || wait_for_irq_instr)
		begin
			cc_r[irq_nest_pkg::CC_HI] <= irq_nest_pkg::LVL0_PAT[1];
			cc_r[irq_nest_pkg::CC_LO] <= irq_nest_pkg::LVL0_PAT[0];
		end
		else if (disable_irq_instr)
		begin
			cc_r[irq_nest_pkg::CC_HI] <= 1'b1;
			cc_r[irq_nest_pkg::CC_LO] <= 1'b1;
		end
		else if (wr_en && idx == irq_nest_pkg::IDX_CCF)
			cc_r <= pwdata[7:0];
	end

	// ==================================================================
	// priority registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prio_r <= {4{irq_nest_pkg::PRIO_RST}};
		else if (wr_en && idx >= irq_nest_pkg::IDX_PRIO0 && idx <= irq_nest_pkg::IDX_PRIO3)
		begin
			for (int k = 0; k < 4; k++)
				if (idx == irq_nest_pkg::IDX_PRIO0 + 8'(k))
					prio_r[8*k+:8] <= fld_wr(prio_r[8*k+:8], pwdata[7:0])
							| ((k == 3) ? irq_nest_pkg::PRIO3_RO : 8'h00);
		end
	end

	// ==================================================================
	// apb read data captured in setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rd_r  <= 8'h00;
			err_r <= 1'b0;
		end
		else if (rd_setup)
		begin
			err_r <= !idx_ok;
			case (idx)
				irq_nest_pkg::IDX_PRIO0:  rd_r <= prio_r[7:0];
				irq_nest_pkg::IDX_PRIO1:  rd_r <= prio_r[15:8];
				irq_nest_pkg::IDX_PRIO2:  rd_r <= prio_r[23:16];
				irq_nest_pkg::IDX_PRIO3:  rd_r <= prio_r[31:24] | irq_nest_pkg::PRIO3_RO;
				irq_nest_pkg::IDX_SENSE:  rd_r <= sense_r;
				irq_nest_pkg::IDX_CCF:    rd_r <= cc_r;
				irq_nest_pkg::IDX_STATUS: rd_r <= {req_r, ext_pend, 3'h0} | {4'h0, vec_r};
				default:                  rd_r <= 8'h00;
			endcase
		end
	end

	assign pready  = 1'b1;
	assign prdata  = {24'h0, rd_r};
	assign pslverr = psel && penable && err_r;

	// ==================================================================
	// wake qualification
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hw_r  <= 1'b0;
			ahw_r <= 1'b0;
		end
		else
		begin
			hw_r  <= |ext_pend || pend[irq_nest_pkg::VEC_SPI];
			ahw_r <= pend[irq_nest_pkg::VEC_TB] || (MASK_ROM_VARIANT
					&& (|ext_pend || pend[irq_nest_pkg::VEC_SPI]));
		end
	end

	assign cpu_condition_flags = cc_r;
	assign irq_req             = req_r;
	assign irq_vec             = vec_r;
	assign irq_vaddr           = vaddr_r;
	assign reset_vaddr         = irq_nest_pkg::VADDR_RESET;
	assign trap_vaddr          = irq_nest_pkg::VADDR_TRAP;
	assign branch_if_masked    = lvl3;
	assign branch_if_unmasked  = !lvl3;
	assign halt_wake           = hw_r;
	assign active_halt_wake    = ahw_r;

	// ==================================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence only_take_s;
		irq_take && !trap_take;
	endsequence
	sequence plain_instr_s;
		!irq_take && !trap_take && !return_from_irq_instr && !pop_cc_instr;
	endsequence

	entry_level_a: assert property (only_take_s |=> cur_pat == $past(prio_r[2*irq_take_vec+:2]))
		else $error("entry level not loaded");
	enable_lvl0_a: assert property (plain_instr_s ##0 enable_irq_instr |=> cur_pat == 2'h2)
		else $error("enable did not give level 0");
	disable_lvl3_a: assert property (plain_instr_s ##0 disable_irq_instr && !enable_irq_instr
			&& !halt_instr && !wait_for_irq_instr |=> lvl3)
		else $error("disable did not give level 3");
	trap_lvl3_a: assert property (trap_take && !irq_take |=> lvl3 && branch_if_masked)
		else $error("trap did not mask");
	wait_lvl0_a: assert property (plain_instr_s ##0 wait_for_irq_instr |=> !lvl3 ##0 cur_pat == 2'h2)
		else $error("wait did not give level 0");
	no_lvl0_field_a: assert property (prio_r[1:0] != 2'h2 && prio_r[15:14] != 2'h2
			&& prio_r[27:26] != 2'h2)
		else $error("level 0 pattern stored");
	prio3_upper_a: assert property (psel && !penable && idx == irq_nest_pkg::IDX_PRIO3
			|=> rd_r[7:4] == 4'hf)
		else $error("upper nibble not ones");
	sense_lock_a: assert property (sense_r != $past(sense_r) |-> $past(lvl3))
		else $error("sense changed outside level 3");
	unused_vec_a: assert property (irq_req |-> irq_vec != 4'h0 && irq_vec != 4'h6
			&& irq_vaddr == 16'hfffa - {11'h0, irq_vec, 1'b0})
		else $error("bad vector requested");
	halt_wake_a: assert property (halt_wake |-> $past(|ext_pend || pend[7]))
		else $error("halt wake without cause");
endmodule
`default_nettype wire

// ==== cpu_take_model.sv ====
// Purpose: cpu-side partner that enters the vector the controller requests
// Assumes: irq_req and irq_vec are registered levels from the controller
// Notes:   the bench sets the wait before a take, so answers are prompt or slow
`timescale 1ns/1ns
`default_nettype none
module cpu_take_model (
	input  wire logic       pclk,     // cpu clock
	input  wire logic       presetn,  // async reset, low
	input  wire logic       acc,      // servicing allowed
	input  wire logic [2:0] dly,      // cycles before taking
	input  wire logic       irq_req,  // request level
	input  wire logic [3:0] irq_vec,  // chosen vector
	output logic            take,     // entry pulse
	output logic [3:0]      take_vec  // entered vector
);
	logic [2:0] cnt_r;
	logic [2:0] hold_r;

	// ==================================================================
	// take once, then hold off: the request only drops a few cycles later
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_r <= 3'h0;
			hold_r <= 3'h0;
			take <= 1'b0;
			take_vec <= 4'h0;
		end
		else if (hold_r != 3'h0)
		begin
			hold_r <= hold_r - 3'h1;
			take <= 1'b0;
			take_vec <= ~take_vec; // not meaningful outside a take
		end
		else if (acc && irq_req && cnt_r == dly)
		begin
			take <= 1'b1;
			take_vec <= irq_vec;
			cnt_r <= 3'h0;
			hold_r <= 3'h5;
		end
		else
		begin
			take <= 1'b0;
			take_vec <= ~take_vec;
			cnt_r <= (acc && irq_req) ? cnt_r + 3'h1 : 3'h0;
		end
	end
endmodule
`default_nettype wire

// ==== test_nested_irq_priority_ctrl.sv ====
// Purpose: self-checking bench for the nested interrupt priority controller
// Assumes: zero-wait apb slave, cpu strobes are one-cycle pulses
// Notes:   an integer model predicts registers, level and vector choice
`timescale 1ns/1ns
`default_nettype none
module test_nested_irq_priority_ctrl;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic        en_i, dis_i, halt_i, wfi_i, pop_i, ret_i, trap_i, take, acc;
	logic        req, bm, bu, hw, ahw;
	logic [9:0]  paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [7:0]  scc, cc;
	logic [3:0]  take_vec, vec, g0, g2, g3;
	logic [2:0]  g1, dly;
	logic [13:0] pirq, mask;
	logic [15:0] vaddr, rv, tv;
	int          fail_count, n_compared, lvl_m, sense_m, best;
	int          prio_m[4];
	int          ops[9] = '{1, 0, 6, 2, 1, 3, 4, 1, 5};

	nested_irq_priority_ctrl u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.enable_irq_instr(en_i), .disable_irq_instr(dis_i), .halt_instr(halt_i),
		.wait_for_irq_instr(wfi_i), .pop_cc_instr(pop_i), .return_from_irq_instr(ret_i),
		.stack_cc(scc), .trap_take(trap_i), .irq_take(take), .irq_take_vec(take_vec),
		.periph_irq(pirq), .ext_line_group_0(g0), .ext_line_group_1(g1),
		.ext_line_group_2(g2), .ext_line_group_3(g3), .cpu_condition_flags(cc),
		.irq_req(req), .irq_vec(vec), .irq_vaddr(vaddr), .reset_vaddr(rv), .trap_vaddr(tv),
		.branch_if_masked(bm), .branch_if_unmasked(bu), .halt_wake(hw),
		.active_halt_wake(ahw)
	);
	cpu_take_model u_cpu (
		.pclk(pclk), .presetn(presetn), .acc(acc), .dly(dly), .irq_req(req),
		.irq_vec(vec), .take(take), .take_vec(take_vec)
	);

	// ==================================================================
	// clock
	always #2 pclk = ~pclk;

	// ==================================================================
	// model helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic int lvl(input logic [1:0] p);
		return (p == 2'h2) ? 0 : (p == 2'h1) ? 1 : (p == 2'h0) ? 2 : 3;
	endfunction
	function automatic logic [1:0] pat(input int l);
		return (l == 0) ? 2'h2 : (l == 1) ? 2'h1 : (l == 2) ? 2'h0 : 2'h3;
	endfunction
	function automatic logic [1:0] fld(input int v);
		return 2'(prio_m[v / 4] >> (2 * (v % 4)));
	endfunction
	// ties keep the lower vector because only a strictly higher level replaces it
	function automatic int pick(input logic [13:0] m);
		int b;
		b = -1;
		for (int v = 0; v < irq_nest_pkg::NVEC; v++)
			if (m[v] && irq_nest_pkg::VEC_USED[v] && lvl(fld(v)) > lvl_m
				&& (b < 0 || lvl(fld(v)) > lvl(fld(b))))
				b = v;
		return b;
	endfunction
	function automatic int pmerge(input int old, input logic [7:0] wd);
		int r;
		r = old;
		for (int i = 0; i < 8; i += 2)
			if (wd[i +: 2] != irq_nest_pkg::LVL0_PAT)
				r = (r & ~(3 << i)) | (wd[i +: 2] << i);
		return r;
	endfunction
	// mode in k[1:0], polarity in k[2], rising test in k[3]
	function automatic logic hit(input int k);
		return (k[1:0] == 2'h3) || (k[0] == (k[3] ^ k[2]));
	endfunction

	// ==================================================================
	// bus, cpu and compare tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'h0};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// the slave sets the pace; only the watchdog ends a hung wait
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr_reg(input logic [7:0] idx, input logic [7:0] wd);
		int i;
		i = int'(idx) - int'(irq_nest_pkg::IDX_PRIO0);
		apb(1'b1, idx, {24'h0, wd});
		if (i >= 0 && i < 4)
			prio_m[i] = pmerge(prio_m[i], wd) | (i == 3 ? 8'hf0 : 8'h00);
		else if (idx == irq_nest_pkg::IDX_SENSE && lvl_m == 3)
			sense_m = wd & irq_nest_pkg::SENSE_WM;
		else if (idx == irq_nest_pkg::IDX_CCF)
			lvl_m = lvl({wd[5], wd[3]});
	endtask
	task automatic rd_chk(input logic [7:0] idx);
		apb(1'b0, idx, 32'h0);
		chk("reg", idx == irq_nest_pkg::IDX_SENSE ? sense_m
			: prio_m[idx - irq_nest_pkg::IDX_PRIO0], rd);
	endtask
	// op: 0 enable, 1 disable, 2 halt, 3 wait, 4 pop, 5 return, 6 trap
	task automatic cpu_op(input int op, input logic [7:0] s);
		@(posedge pclk);
		scc <= s;
		{en_i, dis_i, halt_i, wfi_i, pop_i, ret_i, trap_i} <= 7'h40 >> op;
		@(posedge pclk);
		{en_i, dis_i, halt_i, wfi_i, pop_i, ret_i, trap_i} <= 7'h00;
		lvl_m = (op == 1 || op == 6) ? 3 : (op == 4 || op == 5) ? lvl({s[5], s[3]}) : 0;
	endtask
	task automatic chk_lvl();
		#1;
		chk("level", pat(lvl_m), {cc[irq_nest_pkg::CC_HI], cc[irq_nest_pkg::CC_LO]});
		chk("masked", lvl_m == 3, bm);
		chk("unmasked", lvl_m != 3, bu);
	endtask
	task automatic wait_take();
		int n;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (take !== 1'b1 && n < 20);
		acc <= 1'b0;
		chk("take seen", 1, take);
	endtask
	task automatic report_and_stop();
		if (fail_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ==================================================================
	// main sequence
	initial
	begin
		seed = 32'h0000cd70;
		{pclk, psel, penable, pwrite, paddr, pwdata, scc, pirq, acc, presetn} = '0;
		{en_i, dis_i, halt_i, wfi_i, pop_i, ret_i, trap_i} = 7'h00;
		{g0, g1, g2, g3} = '1;
		dly = 3'h1;
		lvl_m = 3;
		sense_m = 0;
		prio_m = '{4{255}};
		fail_count = 0;
		n_compared = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk("cc", irq_nest_pkg::CC_RST, cc);
		chk("masked", 1, bm);
		chk("reset vaddr", 16'hfffe, rv);
		chk("trap vaddr", 16'hfffc, tv);
		for (int r = 0; r < 5; r++)
			rd_chk(irq_nest_pkg::IDX_PRIO0 + 8'(r));
		apb(1'b0, 8'h30, 32'h0);
		chk("slverr", 1, err);
		wr_reg(irq_nest_pkg::IDX_PRIO0, 8'hcf);
		wr_reg(irq_nest_pkg::IDX_PRIO0, 8'h64);
		rd_chk(irq_nest_pkg::IDX_PRIO0);
		foreach (ops[j])
		begin
			cpu_op(ops[j], 8'(rnd()));
			chk_lvl();
		end
		// software may also write the condition byte over the bus
		wr_reg(irq_nest_pkg::IDX_CCF, 8'(rnd()));
		chk_lvl();
		// random priorities and requests, at most one take each, then a raised field
		for (int t = 0; t < 8; t++)
		begin
			for (int r = 0; r < 4; r++)
				wr_reg(irq_nest_pkg::IDX_PRIO0 + 8'(r), 8'(rnd()));
			for (int r = 0; r < 4; r++)
				rd_chk(irq_nest_pkg::IDX_PRIO0 + 8'(r));
			cpu_op(0, 8'h00);
			mask = 14'(rnd()) & 14'h3f82;
			best = pick(mask);
			@(posedge pclk);
			pirq <= mask;
			repeat (3) @(posedge pclk);
			#1;
			chk("req", best >= 0, req);
			chk("halt wake", mask[irq_nest_pkg::VEC_SPI], hw);
			chk("active wake", mask[irq_nest_pkg::VEC_TB], ahw);
			if (best >= 0)
			begin
				chk("vec", best, vec);
				chk("vaddr", irq_nest_pkg::VADDR_V0 - 16'(2 * best), vaddr);
				dly <= 3'(rnd());
				acc <= 1'b1;
				wait_take();
				lvl_m = lvl(fld(best));
				chk_lvl();
				if (lvl_m < 3)
				begin
					wr_reg(irq_nest_pkg::IDX_PRIO0 + 8'(best / 4),
						8'(prio_m[best / 4] | (3 << 2 * (best % 4))));
					repeat (3) @(posedge pclk);
					#1;
					chk("reentry", best, req ? vec : 4'hf);
				end
			end
			@(posedge pclk);
			pirq <= 14'h0;
			cpu_op(5, 8'hfa);
		end
		// every sense mode with both polarities on group 0, stale edges cleared
		for (int k = 0; k < 16; k++)
		begin
			cpu_op(1, 8'h00);
			@(posedge pclk);
			g0 <= k[3] ? 4'h0 : 4'hf;
			wr_reg(irq_nest_pkg::IDX_SENSE, 8'h80);
			wr_reg(irq_nest_pkg::IDX_SENSE, 8'({k[1:0], k[2], 2'h3}));
			rd_chk(irq_nest_pkg::IDX_SENSE);
			cpu_op(0, 8'h00);
			@(posedge pclk);
			g0 <= k[3] ? 4'hf : 4'h0;
			repeat (3) @(posedge pclk);
			#1;
			chk("edge req", hit(k), req);
			chk("ext halt wake", hit(k), hw);
			chk("ext active wake", 0, ahw);
		end
		wr_reg(irq_nest_pkg::IDX_SENSE, 8'h40);
		rd_chk(irq_nest_pkg::IDX_SENSE);
		report_and_stop();
	end

	// ==================================================================
	// watchdog, far beyond the expected run length
	initial
	begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
